//--- adcs_defs.svh
/*
  Shared constants of the conversion sequencer: times in their own units,
  frame layout and output codes.
  Assumes a 40 MHz system clock; cycle counts are derived where used.
*/
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH

`define ADCS_CLK_MHZ        40
`define ADCS_NS_PER_US      1000
`define ADCS_T_CONV_US      147000
`define ADCS_T_POR_US       4000
`define ADCS_T_DET_US       200
`define ADCS_T_DOUT_NS      620000
`define ADCS_EXT_CONV_TICKS 41036
`define ADCS_EXT_SCK_HALF   4
`define ADCS_FRAME_BITS     24
`define ADCS_LAST_BIT       5'h17
`define ADCS_FRAME_END      5'h18
`define ADCS_HDR            2'h0
`define ADCS_TAIL           4'h0
`define ADCS_OVER_RES       17'h10000
`define ADCS_UNDER_RES      17'h0FFFF
`define ADCS_CAL_NONE       2'h0
`define ADCS_CAL_OFFSET     2'h1
`define ADCS_CAL_GAIN       2'h2

`endif

//--- adcs_pkg.sv
/*
  Types of the conversion sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package adcs_pkg;
  typedef enum logic [1:0] {st_por, st_convert, st_sleep, st_output} adcs_state_t;
endpackage

//--- adcs_edge_count.sv
/*
  Link-side counter of falling serial clock edges, gray coded for the crossing.
  Assumes the serial clock stops outside frames; chip select high clears it.
*/
`timescale 1ns/100ps
`include "adcs_defs.svh"
module adcs_edge_count
  import adcs_pkg::*;
(
  input  wire logic       sck,
  input  wire logic       cs_n,
  output logic      [4:0] edge_gray
);
  typedef struct packed {
    logic [4:0] bin;
    logic [4:0] gray;
  } adcs_link_t;

  adcs_link_t q;
  adcs_link_t next_q;

  always_comb begin
    next_q      = q;
    next_q.bin  = q.bin + 5'h1;
    next_q.gray = next_q.bin ^ (next_q.bin >> 1);
  end

  // frame's own select ends the count; no edge needed after the frame
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign edge_gray = q.gray;
endmodule // adcs_edge_count

//--- adcs_clk_detect.sv
/*
  Detects a toggling conversion clock on the rejection clock pin.
  Assumes the pin is asynchronous to clock; slowest accepted clock is 10 kHz.
*/
`timescale 1ns/100ps
`include "adcs_defs.svh"
module adcs_clk_detect
  import adcs_pkg::*;
#(
  parameter int DET_CYCLES = `ADCS_T_DET_US * `ADCS_CLK_MHZ
)
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic rejection_clock_pin,
  output logic      ext_present,
  output logic      ext_tick
);
  typedef struct packed {
    logic [2:0]  s;
    logic [1:0]  fill;
    logic        lvl;
    logic [15:0] tmr;
    logic        present;
    logic        tick;
  } adcs_det_t;

  adcs_det_t q;
  adcs_det_t next_q;

  always_comb begin
    next_q      = q;
    next_q.s    = {q.s[1:0], rejection_clock_pin};
    next_q.tick = 1'b0;
    if (q.fill != 2'h3) begin
      // seed from the pin so a pin parked high gives no false edge
      next_q.fill = q.fill + 2'h1;
      next_q.lvl  = q.s[1];
    end else if (q.s[1] == q.s[2]) begin
      next_q.lvl = q.s[2];
    end
    if (next_q.lvl && !q.lvl && q.fill == 2'h3) begin
      next_q.tick    = 1'b1;
      next_q.tmr     = '0;
      next_q.present = 1'b1;
    end else if (q.tmr == 16'(DET_CYCLES - 1)) begin
      // timeout spans two slowest periods, so a valid clock never drops out
      next_q.present = 1'b0;
    end else begin
      next_q.tmr = q.tmr + 16'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign ext_present = q.present;
  assign ext_tick    = q.tick;

  drop_timeout_a: assert property (@(posedge clock) disable iff (rst)
    (q.tmr == 16'(DET_CYCLES - 1) && !next_q.tick) |=> !ext_present)
    else $error("external clock not dropped after timeout");
endmodule // adcs_clk_detect

//--- adcs_sequencer.sv
/*
  Conversion sequencer: clock source choice, power-on reset, convert, sleep
  and data output states, serial frame and range codes.
  Assumes the modulator presents sample_* stable at the end of each conversion
  and that the serial clock pin is also wired to the sck clock port.
*/
`timescale 1ns/100ps
`include "adcs_defs.svh"
module adcs_sequencer
  import adcs_pkg::*;
#(
  parameter int CONV_CYCLES = `ADCS_T_CONV_US * `ADCS_CLK_MHZ,
  parameter int POR_CYCLES  = `ADCS_T_POR_US * `ADCS_CLK_MHZ,
  parameter int DET_CYCLES  = `ADCS_T_DET_US * `ADCS_CLK_MHZ,
  parameter int EXT_TICKS   = `ADCS_EXT_CONV_TICKS
)
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        rejection_clock_pin,
  input  wire logic        supply_ok,
  input  wire logic [16:0] sample_value,
  input  wire logic        sample_sign,
  input  wire logic        sample_over,
  input  wire logic        sample_under,
  output logic             sdo,
  output logic             sdo_oe,
  output logic             sck_out,
  output logic             sck_oe,
  output logic             int_osc_en,
  output logic             ext_clk_mode,
  output logic             conv_busy,
  output logic             data_ready,
  output logic      [1:0]  cal_phase
);
  // longest half period that keeps 24 bits inside the output limit
  localparam int SCK_HALF = (`ADCS_T_DOUT_NS * `ADCS_CLK_MHZ) / (`ADCS_NS_PER_US * 2 * `ADCS_FRAME_BITS);

  typedef struct packed {
    adcs_state_t st;
    logic [22:0] tmr;
    logic [23:0] frame;
    logic [4:0]  idx;
    logic [4:0]  base;
    logic [9:0]  div;
    logic        int_sck;
    logic        sck_o;
    logic        sck_en;
    logic        sdo;
    logic        sdo_en;
    logic [2:0]  cs_s;
    logic        cs_f;
    logic        cs_prev;
    logic [2:0]  sck_s;
    logic        sck_f;
    logic [2:0]  sup_s;
    logic        sup_f;
    logic [4:0]  g1;
    logic [4:0]  g2;
    logic [4:0]  g3;
    logic [4:0]  gcnt;
    logic        osc_en;
    logic        ext;
    logic        busy;
    logic        ready;
    logic [1:0]  cal;
  } adcs_seq_t;

  adcs_seq_t  q;
  adcs_seq_t  next_q;
  logic [4:0] edge_gray;
  logic       ext_present;
  logic       ext_tick;

  function automatic logic [4:0] gray_to_bin(input logic [4:0] g);
    logic [4:0] b;
    b[4] = g[4];
    for (int i = 3; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

  adcs_clk_detect #(
    .DET_CYCLES (DET_CYCLES)
  ) u_detect (
    .clock               (clock),
    .rst                 (rst),
    .rejection_clock_pin (rejection_clock_pin),
    .ext_present         (ext_present),
    .ext_tick            (ext_tick)
  );

  adcs_edge_count u_link (
    .sck       (sck),
    .cs_n      (cs_n),
    .edge_gray (edge_gray)
  );

  logic        cs_fall;
  logic        cs_rise;
  logic        step;
  logic [22:0] limit;
  logic [4:0]  ext_idx;
  logic [9:0]  half;
  logic [16:0] res;
  logic        sgn;

  always_comb begin
    next_q  = q;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    step    = 1'b0;
    limit   = '0;
    ext_idx = '0;
    half    = '0;
    res     = '0;
    sgn     = 1'b0;

    next_q.cs_s  = {q.cs_s[1:0], cs_n};
    next_q.sck_s = {q.sck_s[1:0], sck};
    next_q.sup_s = {q.sup_s[1:0], supply_ok};
    next_q.g1    = edge_gray;
    next_q.g2    = q.g1;
    next_q.g3    = q.g2;
    if (q.cs_s[1] == q.cs_s[2]) begin
      next_q.cs_f = q.cs_s[2];
    end
    if (q.sck_s[1] == q.sck_s[2]) begin
      next_q.sck_f = q.sck_s[2];
    end
    if (q.sup_s[1] == q.sup_s[2]) begin
      next_q.sup_f = q.sup_s[2];
    end
    if (q.g2 == q.g3) begin
      next_q.gcnt = gray_to_bin(q.g3);
    end
    next_q.cs_prev = q.cs_f;
    cs_fall        = q.cs_prev & ~q.cs_f;
    cs_rise        = ~q.cs_prev & q.cs_f;

    next_q.ext    = ext_present;
    next_q.osc_en = ~ext_present;
    // source may change at any time; counters keep running in the new unit
    step    = q.ext ? ext_tick : 1'b1;
    limit   = q.ext ? 23'(EXT_TICKS) : 23'(CONV_CYCLES);
    half    = q.ext ? 10'(`ADCS_EXT_SCK_HALF) : 10'(SCK_HALF);
    ext_idx = q.gcnt - q.base;

    // stale mode would drive the clock pin for a cycle at the next select
    if (q.cs_f) begin
      next_q.int_sck = 1'b0;
    end
    if (cs_fall) begin
      // serial clock high (pulled up) at select means device drives it
      next_q.int_sck = q.sck_f;
      next_q.base    = q.gcnt;
      next_q.sck_o   = 1'b0;
    end

    unique case (q.st)
      st_por: begin
        next_q.tmr = q.tmr + 23'h1;
        if (q.tmr == 23'(POR_CYCLES - 1)) begin
          next_q.st  = st_convert;
          next_q.tmr = '0;
        end
      end
      st_convert: begin
        if (step) begin
          next_q.tmr = q.tmr + 23'h1;
        end
        // calibration phases ride inside the conversion time
        next_q.cal = (q.tmr < (limit >> 1)) ? `ADCS_CAL_OFFSET : `ADCS_CAL_GAIN;
        // a switch mid-way ends on the new limit; only this result suffers
        if (step && q.tmr >= limit - 23'h1) begin
          next_q.st    = st_sleep;
          next_q.tmr   = '0;
          next_q.idx   = '0;
          next_q.base  = q.gcnt;
          next_q.cal   = `ADCS_CAL_NONE;
          next_q.ready = 1'b1;
          res          = sample_value;
          sgn          = sample_sign;
          if (sample_over) begin
            res = `ADCS_OVER_RES;
            sgn = 1'b1;
          end else if (sample_under) begin
            res = `ADCS_UNDER_RES;
            sgn = 1'b0;
          end
          next_q.frame = {`ADCS_HDR, sgn, res, `ADCS_TAIL};
        end
      end
      st_sleep: begin
        if (!q.cs_f && !cs_fall) begin
          if (q.int_sck) begin
            next_q.st  = st_output;
            next_q.div = '0;
            next_q.idx = '0;
          end else if (ext_idx != 5'h0) begin
            // host keeps its clock low at select to get here
            next_q.st  = st_output;
            next_q.idx = ext_idx;
          end
        end
      end
      st_output: begin
        if (cs_rise) begin
          next_q.st    = st_convert;
          next_q.tmr   = '0;
          next_q.sck_o = 1'b0;
          next_q.ready = 1'b0;
        end else if (!q.int_sck) begin
          next_q.idx = ext_idx;
          if (ext_idx >= `ADCS_FRAME_END) begin
            next_q.st    = st_convert;
            next_q.tmr   = '0;
            next_q.ready = 1'b0;
          end
        end else if (step) begin
          // half period follows the active source; duty may shift, bits hold
          next_q.div = q.div + 10'h1;
          if (q.div >= half - 10'h1) begin
            next_q.div   = '0;
            next_q.sck_o = ~q.sck_o;
            if (q.sck_o) begin
              next_q.idx = q.idx + 5'h1;
              if (q.idx == `ADCS_LAST_BIT) begin
                next_q.st    = st_convert;
                next_q.tmr   = '0;
                next_q.ready = 1'b0;
              end
            end
          end
        end
      end
    endcase

    // low supply overrides everything and clears the result
    if (!q.sup_f) begin
      next_q.st    = st_por;
      next_q.tmr   = '0;
      next_q.frame = '0;
      next_q.ready = 1'b0;
      next_q.cal   = `ADCS_CAL_NONE;
    end

    next_q.busy   = next_q.st == st_convert;
    next_q.sdo_en = ~next_q.cs_f && next_q.st != st_por;
    next_q.sck_en = ~next_q.cs_f && next_q.int_sck && next_q.st != st_por;
    if (next_q.st == st_sleep || next_q.st == st_output) begin
      next_q.sdo = next_q.frame[`ADCS_LAST_BIT - next_q.idx];
    end else begin
      // busy or surplus clocks read as one
      next_q.sdo = 1'b1;
    end
    if (next_q.st != st_output) begin
      next_q.sck_o = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q       <= '0;
      q.st    <= st_por;
      q.cs_s  <= 3'h7;
      q.cs_f  <= 1'b1;
      q.cs_prev <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign sdo          = q.sdo;
  assign sdo_oe       = q.sdo_en;
  assign sck_out      = q.sck_o;
  assign sck_oe       = q.sck_en;
  assign int_osc_en   = q.osc_en;
  assign ext_clk_mode = q.ext;
  assign conv_busy    = q.busy;
  assign data_ready   = q.ready;
  assign cal_phase    = q.cal;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  osc_off_a: assert property (ext_present |=> !int_osc_en && ext_clk_mode)
    else $error("oscillator not off with external clock");

  osc_on_a: assert property (!ext_present |=> int_osc_en)
    else $error("oscillator not on without external clock");

  supply_hold_a: assert property (!q.sup_f |=> q.st == st_por && !sdo_oe)
    else $error("not held in reset at low supply");

  por_exit_a: assert property ((q.st == st_por && q.sup_f && q.tmr == 23'(POR_CYCLES - 1)) |=> conv_busy)
    else $error("no conversion after power-on reset");

  conv_int_a: assert property ((q.st == st_convert && !q.ext && q.sup_f && q.tmr < 23'(CONV_CYCLES - 1))
    |=> q.st == st_convert)
    else $error("internal conversion ended early");

  conv_ext_a: assert property ((q.st == st_convert && q.ext && !ext_tick && q.sup_f) |=> q.st == st_convert)
    else $error("external conversion ended without a clock period");

  sleep_stay_a: assert property ((q.st == st_sleep && q.cs_f && q.sup_f) |=> q.st == st_sleep)
    else $error("sleep left while select high");

  frame_len_a: assert property (q.st == st_output |-> q.idx < `ADCS_FRAME_END)
    else $error("output ran past 24 bits");

  range_code_a: assert property (($past(q.st) == st_convert && q.st == st_sleep && $past(sample_over))
    |-> q.frame[21:20] == 2'h3 && q.frame[19:4] == 16'h0000)
    else $error("overrange code wrong");

  under_code_a: assert property (($past(q.st) == st_convert && q.st == st_sleep && $past(sample_under)
    && !$past(sample_over)) |-> q.frame[21:20] == 2'h0)
    else $error("underrange code wrong");

  frame_tail_a: assert property (q.frame[23:22] == 2'h0 && q.frame[3:0] == 4'h0)
    else $error("frame status or tail bits not zero");

  busy_line_a: assert property ((q.st == st_convert && !q.cs_f) |-> sdo && sdo_oe)
    else $error("data line low during conversion");
endmodule // adcs_sequencer

//--- adcs_host_model.sv
/*
  Host controller model on the serial side: drives chip select and, in
  external clock frames, the serial clock; reads 24-bit frames.
  Assumes the bench resolves the sck and sdo wires from all enables.
*/
`timescale 1ns/100ps
module adcs_host_model (
  input  wire logic sck_line,
  input  wire logic sdo_line,
  output logic      host_sck,
  output logic      host_sck_oe,
  output logic      cs_n
);
  initial begin
    host_sck    = 1'h0;
    host_sck_oe = 1'h1;
    cs_n        = 1'h1;
  end

  // clock idles low outside frames; gaps between bits leave room for sync delay
  task automatic ext_frame(input int n, output logic [23:0] f, output logic tl);
    f = 24'h0;
    tl = 1'h0;
    host_sck_oe = 1'h1;
    host_sck = 1'h0;
    #110 cs_n = 1'h0;
    #300 f[23] = sdo_line;
    for (int k = 1; k <= n; k++) begin
      #62.5 host_sck = 1'h1;
      #62.5 host_sck = 1'h0;
      #250;
      if (k < 24) f[23-k] = sdo_line;
      else tl = sdo_line;
    end
    cs_n = 1'h1;
  endtask

  // released sck floats high on the pull-up, so the device clocks the frame
  task automatic int_frame(output logic [23:0] f, output int cyc);
    logic prev;
    int   k;
    f = 24'h0;
    k = 0;
    cyc = 0;
    prev = 1'h1;
    host_sck_oe = 1'h0;
    #110 cs_n = 1'h0;
    while (k < 24 && cyc < 42000) begin
      #25 cyc++;
      if (sck_line && !prev) begin
        f[23-k] = sdo_line;
        k++;
      end
      prev = sck_line;
    end
    while (sck_line && cyc < 42000) #25 cyc++;
    cs_n = 1'h1;
  endtask
endmodule // adcs_host_model

//--- tb_adcs_sequencer.sv
/*
  Self-checking bench of the conversion sequencer with shortened counts.
  Assumes the host model and the design files are compiled first.
*/
`timescale 1ns/100ps
module tb_adcs_sequencer;
  localparam int CONV  = 200;
  localparam int POR   = 50;
  localparam int DET   = 400;
  localparam int TICKS = 20;
  localparam int EXTP  = 200;

  logic        clock, rst, supply_ok, ext_on, rejection_clock_pin;
  logic [16:0] sample_value;
  logic        sample_sign, sample_over, sample_under;
  logic        sdo, sdo_oe, sck_out, sck_oe, int_osc_en, ext_clk_mode;
  logic        conv_busy, data_ready, sdo_last, tl;
  logic [1:0]  cal_phase;
  logic        host_sck, host_sck_oe, cs_n;
  wire logic   sck_line, sdo_line;
  logic [23:0] f;
  int          n, cyc, n_mismatch, samples_checked;
  logic [19:0] stim [4] = '{{1'h1, 17'h0ABCD, 2'h0}, {1'h0, 17'h1FFFF, 2'h0},
                            {1'h0, 17'h01234, 2'h2}, {1'h1, 17'h05555, 2'h1}};
  logic [23:0] expf [4] = '{24'h2ABCD0, 24'h1FFFF0, 24'h300000, 24'h0FFFF0};

  assign sck_line = sck_oe ? sck_out : (host_sck_oe ? host_sck : 1'h1);
  // undriven sdo must not look like the last bit
  assign sdo_line = sdo_oe ? sdo : ~sdo_last;
  always @(posedge clock) if (sdo_oe) sdo_last <= sdo;
  always #12.5 clock = ~clock;
  // off-grid period keeps the conversion clock unrelated to clock
  always #2503.3 rejection_clock_pin = ext_on ? ~rejection_clock_pin : 1'h0;

  adcs_sequencer #(.CONV_CYCLES(CONV), .POR_CYCLES(POR), .DET_CYCLES(DET), .EXT_TICKS(TICKS)) dut (
    .clock(clock), .rst(rst), .sck(sck_line), .cs_n(cs_n),
    .rejection_clock_pin(rejection_clock_pin), .supply_ok(supply_ok),
    .sample_value(sample_value), .sample_sign(sample_sign), .sample_over(sample_over),
    .sample_under(sample_under), .sdo(sdo), .sdo_oe(sdo_oe), .sck_out(sck_out),
    .sck_oe(sck_oe), .int_osc_en(int_osc_en), .ext_clk_mode(ext_clk_mode),
    .conv_busy(conv_busy), .data_ready(data_ready), .cal_phase(cal_phase));

  adcs_host_model host (.sck_line(sck_line), .sdo_line(sdo_line), .host_sck(host_sck),
    .host_sck_oe(host_sck_oe), .cs_n(cs_n));

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic inrange(input int v, input int lo, input int hi);
    samples_checked++;
    if (v < lo || v > hi) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask

  task automatic wait_for(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v) begin
      @(negedge clock);
      k++;
      if (k > 50000) begin
        n_mismatch++;
        $display("ERROR t=%0t got=%h exp=%h", $time, s, v);
        wrap_up();
      end
    end
  endtask

  task automatic put(input int i);
    @(negedge clock);
    {sample_sign, sample_value, sample_over, sample_under} = stim[i];
  endtask

  initial begin
    clock = 1'h0; rst = 1'h1; supply_ok = 1'h0; ext_on = 1'h0;
    rejection_clock_pin = 1'h0; sdo_last = 1'h0; n_mismatch = 0; samples_checked = 0;
    {sample_sign, sample_value, sample_over, sample_under} = stim[0];
    repeat (16) @(negedge clock);
    cmp({conv_busy, data_ready, sdo_oe, sck_oe}, 24'h0);
    rst = 1'h0;
    supply_ok = 1'h1;
    wait_for(conv_busy, 1'h1, n);
    inrange(n, POR, POR + 8);
    repeat (CONV / 4) @(negedge clock);
    cmp(cal_phase, 24'h1);
    repeat (CONV / 2) @(negedge clock);
    cmp(cal_phase, 24'h2);
    wait_for(conv_busy, 1'h0, n);
    inrange(n + CONV * 3 / 4, CONV - 2, CONV + 4);
    repeat (300) @(negedge clock);
    cmp({conv_busy, data_ready, cal_phase}, 24'h4);
    $display("test power-on and convert done");
    for (int i = 0; i < 4; i++) begin
      if (i > 0) put(i);
      wait_for(data_ready, 1'h1, n);
      host.ext_frame(24, f, tl);
      cmp(f, expf[i]);
      cmp({tl, conv_busy}, 24'h3);
    end
    $display("test external clock frames done");
    wait_for(data_ready, 1'h1, n);
    host.ext_frame(5, f, tl);
    cmp(f[23:18], expf[3][23:18]);
    repeat (8) @(negedge clock);
    cmp(conv_busy, 24'h1);
    wait_for(data_ready, 1'h1, n);
    host.int_frame(f, cyc);
    cmp(f, expf[3]);
    inrange(cyc, 0, 24800 + 40);
    $display("test abort and internal frame done");
    ext_on = 1'h1;
    wait_for(ext_clk_mode, 1'h1, n);
    inrange(n, 0, DET + 2 * EXTP);
    cmp(int_osc_en, 24'h0);
    put(0);
    wait_for(data_ready, 1'h1, n);
    host.ext_frame(24, f, tl);
    wait_for(conv_busy, 1'h0, n);
    inrange(n + 10, (TICKS - 1) * EXTP, (TICKS + 1) * EXTP);
    host.int_frame(f, cyc);
    cmp(f, expf[0]);
    inrange(cyc, 0, 192 * (EXTP + 1));
    put(1);
    wait_for(data_ready, 1'h1, n);
    ext_on = 1'h0;
    wait_for(int_osc_en, 1'h1, n);
    inrange(n, DET - EXTP, DET + 20);
    cmp(ext_clk_mode, 24'h0);
    host.ext_frame(24, f, tl);
    cmp(f, expf[1]);
    wait_for(conv_busy, 1'h0, n);
    inrange(n + 5, CONV - 2, CONV + 4);
    $display("test clock source switching done");
    supply_ok = 1'h0;
    repeat (5) @(negedge clock);
    cmp({conv_busy, data_ready, sdo_oe}, 24'h0);
    supply_ok = 1'h1;
    wait_for(conv_busy, 1'h1, n);
    inrange(n, POR, POR + 10);
    $display("test supply drop done");
    wrap_up();
  end
endmodule // tb_adcs_sequencer
